// ==== flash_command_decoder_tb.sv ====
// self-checking bench for the host command sequencer
`timescale 1ns/1ns
module flash_command_decoder_tb;
	typedef struct {logic rd; logic [19:0] a, am; logic [15:0] d, dm;} note_t;
	localparam logic [19:0] M = 20'h007FF;
	logic sys_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, byte_mode = 1'b0;
	nor_cmd_pkg::op_t cmd_op = nor_cmd_pkg::OP_READ;
	logic [19:0] cmd_addr = 20'h00000, flash_addr, cap_a;
	logic [15:0] cmd_data = 16'h0000, read_data_r, flash_dq_out, flash_dq_in;
	logic cmd_ready, cmd_done, cmd_refused, bypass_r, erasing_r, suspended_r, window_open;
	logic chip_en_n, write_en_n, out_en_n, flash_dq_oe;
	int num_errors = 0, num_checks = 0, cyc = 0;
	note_t q[$], n;
	always #25 sys_clk = ~sys_clk;
	nor_cmd_host i_nor_cmd_host (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .byte_mode(byte_mode), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_done(cmd_done),
		.cmd_refused(cmd_refused), .read_data_r(read_data_r), .bypass_r(bypass_r), .erasing_r(erasing_r),
		.suspended_r(suspended_r), .window_open(window_open), .chip_en_n(chip_en_n), .write_en_n(write_en_n),
		.out_en_n(out_en_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in));
	nor_flash_model i_nor_flash_model (.chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
		.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	// expected command write
	task automatic wc(input logic [19:0] a, input logic [19:0] am, input logic [7:0] c);
		q.push_back('{1'b0, a, am, {8'h00, c}, 16'hFFFF});
	endtask
	task automatic ul();
		wc(20'h00555, M, 8'hAA);
		wc(20'h002AA, M, 8'h55);
	endtask
	task automatic u3(input logic [7:0] c);
		ul();
		wc(20'h00555, M, c);
	endtask
	task automatic z(input nor_cmd_pkg::op_t op, input logic rf);
		go(op, 20'h0, 16'h0000, rf);
	endtask
	// one request; mode flags settle a cycle after done
	task automatic go(input nor_cmd_pkg::op_t op, input logic [19:0] a, input logic [15:0] d, input logic rf);
		int k;
		k = 0;
		@(negedge sys_clk);
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		cmd_valid = 1'b1;
		#5;
		chk(cmd_refused === rf, "refusal differs");
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		while (!rf && cmd_done !== 1'b1 && k < 400) begin
			@(negedge sys_clk);
			k++;
		end
		chk(k < 400, "no completion");
		@(negedge sys_clk);
	endtask
	// write cycles: address at strobe fall, data at strobe rise
	always @(negedge write_en_n) cap_a = flash_addr;
	always @(posedge write_en_n) if (resetn) begin
		chk(q.size() > 0 && !q[0].rd, "unexpected write cycle");
		if (q.size() > 0) begin
			n = q.pop_front();
			chk(((cap_a ^ n.a) & n.am) === 20'h00000, "write address wrong");
			chk(((flash_dq_out ^ n.d) & n.dm) === 16'h0000, "write data wrong");
		end
	end
	always @(negedge sys_clk) if (cmd_done === 1'b1 && q.size() > 0 && q[0].rd) begin
		n = q.pop_front();
		chk(((read_data_r ^ n.d) & n.dm) === 16'h0000, "read data wrong");
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			$display("[ERR] %0t timeout", $time);
			stop_test();
		end
	end
	initial begin
		logic [19:0] a, s;
		logic [15:0] d;
		logic [7:0] e;
		logic [7:0] ofs [5] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h02};
		void'($urandom(31));
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		// plain reads need no unlock
		for (int i = 0; i < 3; i++) begin
			a = $urandom();
			q.push_back('{1'b1, 20'h0, 20'h0, a[15:0] ^ 16'hA5C3, 16'hFFFF});
			go(nor_cmd_pkg::OP_READ, a, 16'h0000, 1'b0);
		end
		// identification, lock indicator, protected and open sector
		for (int i = 0; i < 5; i++) begin
			a = $urandom();
			a[7:0] = ofs[i];
			a[12] = i[0];
			e = (i == 0) ? 8'h5A : (i == 1) ? 8'h3C : (i == 2) ? 8'h81 : {7'h00, a[12]};
			ul();
			wc({a[19:12], 12'h555}, 20'hFFFFF, 8'h90);
			q.push_back('{1'b1, 20'h0, 20'h0, {8'h00, e}, 16'h00FF});
			go(nor_cmd_pkg::OP_AUTOSEL, a, 16'h0000, 1'b0);
			wc(20'h0, 20'h0, 8'hF0);
			z(nor_cmd_pkg::OP_RESET, 1'b0);
		end
		u3(8'h88);
		z(nor_cmd_pkg::OP_REGION_IN, 1'b0);
		u3(8'h90);
		wc(20'h0, 20'h0, 8'h00);
		z(nor_cmd_pkg::OP_REGION_OUT, 1'b0);
		a = $urandom();
		d = $urandom();
		u3(8'hA0);
		q.push_back('{1'b0, a, 20'hFFFFF, d, 16'hFFFF});
		go(nor_cmd_pkg::OP_PROGRAM, a, d, 1'b0);
		go(nor_cmd_pkg::OP_BYPASS_PROG, a, d, 1'b1);
		u3(8'h20);
		z(nor_cmd_pkg::OP_BYPASS_IN, 1'b0);
		chk(bypass_r === 1'b1, "bypass not entered");
		go(nor_cmd_pkg::OP_PROGRAM, a, d, 1'b1);
		wc(20'h0, 20'h0, 8'hA0);
		q.push_back('{1'b0, ~a, 20'hFFFFF, ~d, 16'hFFFF});
		go(nor_cmd_pkg::OP_BYPASS_PROG, ~a, ~d, 1'b0);
		wc(20'h0, 20'h0, 8'h90);
		wc(20'h0, 20'h0, 8'h00);
		z(nor_cmd_pkg::OP_BYPASS_OUT, 1'b0);
		chk(bypass_r === 1'b0, "bypass not left");
		// query in word then byte addressing
		for (int i = 0; i < 2; i++) begin
			byte_mode = i[0];
			wc(i ? 20'h000AA : 20'h00055, M, 8'h98);
			z(nor_cmd_pkg::OP_QUERY, 1'b0);
			wc(20'h0, 20'h0, 8'hF0);
			z(nor_cmd_pkg::OP_RESET, 1'b0);
		end
		byte_mode = 1'b0;
		u3(8'h80);
		u3(8'h10);
		z(nor_cmd_pkg::OP_CHIP_ERASE, 1'b0);
		z(nor_cmd_pkg::OP_SUSPEND, 1'b1);
		z(nor_cmd_pkg::OP_RESUME, 1'b1);
		z(nor_cmd_pkg::OP_SECT_ADD, 1'b1);
		// sector erase, add a sector, suspend, program, resume
		s = $urandom();
		u3(8'h80);
		ul();
		wc(s, 20'hFF000, 8'h30);
		go(nor_cmd_pkg::OP_SECT_ERASE, s, 16'h0000, 1'b0);
		chk(erasing_r === 1'b1 && window_open === 1'b1, "erase window not open");
		wc(~s, 20'hFF000, 8'h30);
		go(nor_cmd_pkg::OP_SECT_ADD, ~s, 16'h0000, 1'b0);
		go(nor_cmd_pkg::OP_PROGRAM, a, d, 1'b1);
		wc(s, 20'hFF800, 8'hB0);
		go(nor_cmd_pkg::OP_SUSPEND, s, 16'h0000, 1'b0);
		chk(suspended_r === 1'b1 && window_open === 1'b0, "suspend not in effect");
		go(nor_cmd_pkg::OP_SUSPEND, s, 16'h0000, 1'b1);
		u3(8'hA0);
		q.push_back('{1'b0, a, 20'hFFFFF, d, 16'hFFFF});
		go(nor_cmd_pkg::OP_PROGRAM, a, d, 1'b0);
		wc(s, 20'hFF800, 8'h30);
		go(nor_cmd_pkg::OP_RESUME, s, 16'h0000, 1'b0);
		chk(suspended_r === 1'b0, "resume not in effect");
		go(nor_cmd_pkg::OP_RESUME, s, 16'h0000, 1'b1);
		repeat (4) @(negedge sys_clk);
		chk(q.size() == 0, "expected cycles missing");
		stop_test();
	end
endmodule // flash_command_decoder_tb

// ==== nor_bus_cycle.sv ====
// one flash bus cycle: write with strobe, or read with output enable
`timescale 1ns/1ns
module nor_bus_cycle (
	input  wire logic                            sys_clk,
	input  wire logic                            resetn,
	input  wire logic                            start,
	input  wire logic                            is_read,
	input  wire logic [nor_cmd_pkg::ADDR_W-1:0]  addr,
	input  wire logic [nor_cmd_pkg::DATA_W-1:0]  wdata,
	output logic                                 done,
	output logic [nor_cmd_pkg::DATA_W-1:0]       rdata_r,
	output logic                                 chip_en_n_r,
	output logic                                 write_en_n_r,
	output logic                                 out_en_n_r,
	output logic [nor_cmd_pkg::ADDR_W-1:0]       addr_out_r,
	output logic [nor_cmd_pkg::DATA_W-1:0]       data_out_r,
	output logic                                 data_oe_r,
	input  wire logic [nor_cmd_pkg::DATA_W-1:0]  data_in
);
	typedef enum logic [2:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD, PH_END} phase_t;
	phase_t                          phase_r;
	logic                            active;
	logic [nor_cmd_pkg::CNT_W-1:0]   cnt_r;
	logic                            read_r;
	logic [nor_cmd_pkg::DATA_W-1:0]  sync1_r;
	logic [nor_cmd_pkg::DATA_W-1:0]  sync2_r;
	logic [nor_cmd_pkg::DATA_W-1:0]  sync3_r;

	// done a cycle after hold, once read data has passed the synchroniser
	assign done   = (phase_r == PH_END);
	assign active = (phase_r == PH_SETUP || (phase_r == PH_STROBE && cnt_r != nor_cmd_pkg::CNT_ZERO));

	// phase sequencing; address settles a cycle before either enable falls
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			phase_r <= PH_IDLE;
			cnt_r   <= nor_cmd_pkg::CNT_ZERO;
			read_r  <= 1'b0;
		end else begin
			case (phase_r)
				PH_IDLE: begin
					if (start) begin
						phase_r <= PH_SETUP;
						read_r  <= is_read;
					end
				end
				PH_SETUP: begin
					phase_r <= PH_STROBE;
					cnt_r   <= nor_cmd_pkg::STROBE_CNT;
				end
				PH_STROBE: begin
					if (cnt_r == nor_cmd_pkg::CNT_ZERO)
						phase_r <= PH_HOLD;
					else
						cnt_r <= cnt_r - 1'b1;
				end
				PH_HOLD: phase_r <= PH_END;
				PH_END: phase_r <= PH_IDLE;
				default: phase_r <= PH_IDLE;
			endcase
		end
	end

	// enables fall and rise together: later fall takes address, first rise data
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			chip_en_n_r  <= 1'b1;
			write_en_n_r <= 1'b1;
			out_en_n_r   <= 1'b1;
			addr_out_r   <= '0;
			data_out_r   <= '0;
			data_oe_r    <= 1'b0;
		end else begin
			if (phase_r == PH_IDLE && start) begin
				addr_out_r <= addr;
				data_out_r <= wdata;
				data_oe_r  <= !is_read;
			end
			chip_en_n_r  <= !active;
			write_en_n_r <= !(active && !read_r);
			out_en_n_r   <= !(active && read_r);
			if (phase_r == PH_HOLD)
				data_oe_r <= 1'b0;
		end
	end

	// read data comes from the pins, so it passes three flops
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			rdata_r <= '0;
		end else begin
			sync1_r <= data_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			if (phase_r == PH_HOLD && sync2_r == sync3_r)
				rdata_r <= sync3_r;
		end
	end
endmodule // nor_bus_cycle

// ==== nor_cmd_host.sv ====
// host-side command sequencer driving a dual-bank parallel nor flash
`timescale 1ns/1ns
// Behaviour
// [R1] all cycles are writes but array read and autoselect fourth cycle
// [R2] only the low data byte carries command codes; upper byte zero
// [R3] high address bits don't care except bank or sector address
// [R4] array read is one read cycle without unlock
// [R5] single F0 write returns bank to read or suspend-read
// [R6] autoselect: AA/555, 55/2AA, 90/bank 555, then a read
// [R7] identification read at bank plus offset 00 or device offset
// [R8] region indicator read at offset 03 word, 06 byte
// [R9] protection query read at sector plus offset 02 word, 04 byte
// [R10] region entry AA,55,88; exit AA,55,90, then 00 anywhere
// [R11] program: AA,55,A0 then data at target location
// [R12] address latched at later falling edge of strobe or chip enable
// [R13] data latched at first rising edge of strobe or chip enable
// [R14] bypass entry AA,55,20; bypass program A0 then data
// [R15] bypass exit: 90 then 00 to any address
// [R16] erase: AA,55,80,AA,55 then 10 chip or 30 at sector
// [R17] bank commands carry the bank address in high bits
// [R18] suspend B0 to bank only during sector erase
// [R19] while suspended, reads, programs and autoselect are allowed
// [R20] resume 30 to bank only while suspended
// [R21] extra sector erase writes must come within 50 us
// [R22] device halts within 20 us; host needs nothing
// [R23] in bypass only bypass program and reset are issued
// [R24] query: 98 to 55 word or AA byte
// [R25] device abandons mismatched sequences; host never sends them
module nor_cmd_host (
	input  wire logic                            sys_clk,
	input  wire logic                            resetn,
	input  wire logic                            cmd_valid,
	output logic                                 cmd_ready,
	input  wire nor_cmd_pkg::op_t                cmd_op,
	input  wire logic                            byte_mode,
	input  wire logic [nor_cmd_pkg::ADDR_W-1:0]  cmd_addr,
	input  wire logic [nor_cmd_pkg::DATA_W-1:0]  cmd_data,
	output logic                                 cmd_done,
	output logic                                 cmd_refused,
	output logic [nor_cmd_pkg::DATA_W-1:0]       read_data_r,
	output logic                                 bypass_r,
	output logic                                 erasing_r,
	output logic                                 suspended_r,
	output logic                                 window_open,
	output logic                                 chip_en_n,
	output logic                                 write_en_n,
	output logic                                 out_en_n,
	output logic [nor_cmd_pkg::ADDR_W-1:0]       flash_addr,
	output logic [nor_cmd_pkg::DATA_W-1:0]       flash_dq_out,
	output logic                                 flash_dq_oe,
	input  wire logic [nor_cmd_pkg::DATA_W-1:0]  flash_dq_in
);
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DONE} state_t;
	state_t                           state_r;
	nor_cmd_pkg::op_t                 op_r;
	logic                             byte_r;
	logic [nor_cmd_pkg::ADDR_W-1:0]   addr_r;
	logic [nor_cmd_pkg::DATA_W-1:0]   data_r;
	logic [2:0]                       step_r;
	logic [2:0]                       last_step;
	logic                             cyc_start;
	logic                             cyc_read;
	logic [nor_cmd_pkg::ADDR_W-1:0]   cyc_addr;
	logic [nor_cmd_pkg::DATA_W-1:0]   cyc_data;
	logic                             cyc_done;
	logic [nor_cmd_pkg::DATA_W-1:0]   cyc_rdata;
	logic [nor_cmd_pkg::CNT_W-1:0]    win_cnt_r;
	logic                             allowed;

	// unlock address: 555/2AA word, AAA/555 byte
	function automatic logic [nor_cmd_pkg::ADDR_W-1:0] unlock_addr(
		input logic [nor_cmd_pkg::ADDR_W-1:0] bank, input logic first, input logic bmode);
		logic [11:0] low;
		low = '0;
		if (bmode)
			low = first ? nor_cmd_pkg::UNLOCK1_BYTE_FULL : {1'b0, nor_cmd_pkg::UNLOCK1_WORD};
		else
			low = first ? {1'b0, nor_cmd_pkg::UNLOCK1_WORD} : {1'b0, nor_cmd_pkg::UNLOCK2_WORD};
		unlock_addr = {bank[nor_cmd_pkg::ADDR_W-1:12], low};
	endfunction

	// command code, upper byte zero
	function automatic logic [nor_cmd_pkg::DATA_W-1:0] code(input logic [7:0] c);
		code = {8'h00, c};
	endfunction

	// cycles per command, counted from zero
	always_comb begin
		case (op_r)
			nor_cmd_pkg::OP_READ, nor_cmd_pkg::OP_RESET, nor_cmd_pkg::OP_SUSPEND,
			nor_cmd_pkg::OP_RESUME, nor_cmd_pkg::OP_QUERY, nor_cmd_pkg::OP_SECT_ADD: last_step = 3'd0;
			nor_cmd_pkg::OP_BYPASS_PROG, nor_cmd_pkg::OP_BYPASS_OUT: last_step = 3'd1;
			nor_cmd_pkg::OP_REGION_IN, nor_cmd_pkg::OP_BYPASS_IN: last_step = 3'd2;
			nor_cmd_pkg::OP_CHIP_ERASE, nor_cmd_pkg::OP_SECT_ERASE: last_step = 3'd5;
			default: last_step = 3'd3;
		endcase
	end

	// legality of the request against the tracked bank state
	always_comb begin
		case (cmd_op)
			// [R23] bypass restricts commands
			nor_cmd_pkg::OP_BYPASS_PROG, nor_cmd_pkg::OP_BYPASS_OUT: allowed = bypass_r;
			// [R18] suspend only in sector erase
			nor_cmd_pkg::OP_SUSPEND: allowed = erasing_r && !suspended_r;
			// [R20] resume only when suspended
			nor_cmd_pkg::OP_RESUME: allowed = suspended_r;
			// [R21] adds only inside the window
			nor_cmd_pkg::OP_SECT_ADD: allowed = window_open && !suspended_r;
			// [R19] suspended bank takes reads, programs, autoselect
			nor_cmd_pkg::OP_READ, nor_cmd_pkg::OP_PROGRAM, nor_cmd_pkg::OP_AUTOSEL,
			nor_cmd_pkg::OP_RESET: allowed = !bypass_r && (!erasing_r || suspended_r);
			default: allowed = !bypass_r && !erasing_r;
		endcase
	end

	assign cmd_ready   = (state_r == ST_IDLE);
	assign cmd_refused = cmd_valid && cmd_ready && !allowed;
	assign cmd_done    = (state_r == ST_DONE);
	assign window_open = (win_cnt_r != nor_cmd_pkg::CNT_ZERO);
	assign cyc_start   = (state_r == ST_ISSUE);

	// address and data of the current cycle
	always_comb begin
		cyc_read = 1'b0;
		cyc_addr = unlock_addr(addr_r, step_r[0] == 1'b0, byte_r);
		cyc_data = code(step_r[0] ? nor_cmd_pkg::CODE_UNLOCK2 : nor_cmd_pkg::CODE_UNLOCK1);
		case (op_r)
			// [R4] plain array read
			nor_cmd_pkg::OP_READ: begin
				cyc_read = 1'b1;
				cyc_addr = addr_r;
			end
			// [R5] reset to any address
			nor_cmd_pkg::OP_RESET: begin
				cyc_addr = addr_r;
				cyc_data = code(nor_cmd_pkg::CODE_RESET);
			end
			// [R18] suspend and resume carry bank address
			nor_cmd_pkg::OP_SUSPEND: begin
				cyc_addr = addr_r;
				cyc_data = code(nor_cmd_pkg::CODE_SUSPEND);
			end
			nor_cmd_pkg::OP_RESUME: begin
				cyc_addr = addr_r;
				cyc_data = code(nor_cmd_pkg::CODE_RESUME);
			end
			// [R21] added sector inside window
			nor_cmd_pkg::OP_SECT_ADD: begin
				cyc_addr = addr_r;
				cyc_data = code(nor_cmd_pkg::CODE_SECT_ER);
			end
			// [R24] flash query entry
			nor_cmd_pkg::OP_QUERY: begin
				cyc_addr = {addr_r[nor_cmd_pkg::ADDR_W-1:11],
					byte_r ? nor_cmd_pkg::QUERY_BYTE : nor_cmd_pkg::QUERY_WORD};
				cyc_data = code(nor_cmd_pkg::CODE_QUERY);
			end
			// [R6] autoselect; [R7] [R8] [R9] caller offset, [R1] fourth is read
			nor_cmd_pkg::OP_AUTOSEL: begin
				if (step_r == 3'd2)
					cyc_data = code(nor_cmd_pkg::CODE_AUTOSEL);
				if (step_r == 3'd3) begin
					cyc_read = 1'b1;
					cyc_addr = addr_r;
				end
			end
			// [R10] region entry and exit
			nor_cmd_pkg::OP_REGION_IN:
				if (step_r == 3'd2)
					cyc_data = code(nor_cmd_pkg::CODE_REGION);
			nor_cmd_pkg::OP_REGION_OUT: begin
				if (step_r == 3'd2)
					cyc_data = code(nor_cmd_pkg::CODE_AUTOSEL);
				if (step_r == 3'd3) begin
					cyc_addr = addr_r;
					cyc_data = code(nor_cmd_pkg::CODE_ZERO);
				end
			end
			// [R11] program; [R2] full word only for data
			nor_cmd_pkg::OP_PROGRAM: begin
				if (step_r == 3'd2)
					cyc_data = code(nor_cmd_pkg::CODE_PROGRAM);
				if (step_r == 3'd3) begin
					cyc_addr = addr_r;
					cyc_data = data_r;
				end
			end
			// [R14] bypass entry and program
			nor_cmd_pkg::OP_BYPASS_IN:
				if (step_r == 3'd2)
					cyc_data = code(nor_cmd_pkg::CODE_BYPASS);
			nor_cmd_pkg::OP_BYPASS_PROG: begin
				cyc_addr = addr_r;
				cyc_data = (step_r == 3'd0) ? code(nor_cmd_pkg::CODE_PROGRAM) : data_r;
			end
			// [R15] bypass exit
			nor_cmd_pkg::OP_BYPASS_OUT: begin
				cyc_addr = addr_r;
				cyc_data = code((step_r == 3'd0) ? nor_cmd_pkg::CODE_AUTOSEL : nor_cmd_pkg::CODE_ZERO);
			end
			// [R16] erase, [R17] sector address in last cycle
			nor_cmd_pkg::OP_CHIP_ERASE, nor_cmd_pkg::OP_SECT_ERASE: begin
				cyc_addr = unlock_addr(addr_r, step_r == 3'd0 || step_r == 3'd2 || step_r == 3'd3
					|| step_r == 3'd5, byte_r);
				if (step_r == 3'd3 || step_r == 3'd4)
					cyc_data = code(step_r == 3'd4 ? nor_cmd_pkg::CODE_UNLOCK2 : nor_cmd_pkg::CODE_UNLOCK1);
				if (step_r == 3'd2)
					cyc_data = code(nor_cmd_pkg::CODE_ERASE_SU);
				if (step_r == 3'd5) begin
					cyc_data = code(op_r == nor_cmd_pkg::OP_CHIP_ERASE ? nor_cmd_pkg::CODE_CHIP_ER
						: nor_cmd_pkg::CODE_SECT_ER);
					if (op_r == nor_cmd_pkg::OP_SECT_ERASE)
						cyc_addr = addr_r;
				end
			end
			default: ;
		endcase
	end

	// sequencing of a command; a refused request is dropped in idle
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			op_r    <= nor_cmd_pkg::OP_READ;
			byte_r  <= 1'b0;
			addr_r  <= '0;
			data_r  <= '0;
			step_r  <= 3'd0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (cmd_valid && allowed) begin
						state_r <= ST_ISSUE;
						op_r    <= cmd_op;
						byte_r  <= byte_mode;
						addr_r  <= cmd_addr;
						data_r  <= cmd_data;
						step_r  <= 3'd0;
					end
				end
				ST_ISSUE: state_r <= ST_WAIT;
				ST_WAIT: begin
					if (cyc_done) begin
						if (step_r == last_step)
							state_r <= ST_DONE;
						else begin
							step_r  <= step_r + 3'd1;
							state_r <= ST_ISSUE;
						end
					end
				end
				ST_DONE: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// read result kept for the caller
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			read_data_r <= '0;
		else if (state_r == ST_WAIT && cyc_done && cyc_read)
			read_data_r <= cyc_rdata;
	end

	// tracked device mode; window restarts on each sector erase write
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bypass_r    <= 1'b0;
			erasing_r   <= 1'b0;
			suspended_r <= 1'b0;
			win_cnt_r   <= nor_cmd_pkg::CNT_ZERO;
		end else begin
			if (win_cnt_r != nor_cmd_pkg::CNT_ZERO)
				win_cnt_r <= win_cnt_r - 1'b1;
			if (state_r == ST_DONE) begin
				case (op_r)
					nor_cmd_pkg::OP_BYPASS_IN: bypass_r <= 1'b1;
					nor_cmd_pkg::OP_BYPASS_OUT: bypass_r <= 1'b0;
					// [R21] window opens and restarts
					nor_cmd_pkg::OP_SECT_ERASE, nor_cmd_pkg::OP_SECT_ADD: begin
						erasing_r <= 1'b1;
						win_cnt_r <= nor_cmd_pkg::WINDOW_CNT;
					end
					// [R22] suspend in window ends it at once
					nor_cmd_pkg::OP_SUSPEND: begin
						suspended_r <= 1'b1;
						win_cnt_r   <= nor_cmd_pkg::CNT_ZERO;
					end
					nor_cmd_pkg::OP_RESUME: suspended_r <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	// [R12] [R13] strobe edges shaped by the cycle engine
	nor_bus_cycle u_cycle (
		.sys_clk      (sys_clk),
		.resetn       (resetn),
		.start        (cyc_start),
		.is_read      (cyc_read),
		.addr         (cyc_addr),
		.wdata        (cyc_data),
		.done         (cyc_done),
		.rdata_r      (cyc_rdata),
		.chip_en_n_r  (chip_en_n),
		.write_en_n_r (write_en_n),
		.out_en_n_r   (out_en_n),
		.addr_out_r   (flash_addr),
		.data_out_r   (flash_dq_out),
		.data_oe_r    (flash_dq_oe),
		.data_in      (flash_dq_in)
	);
endmodule // nor_cmd_host

// ==== nor_cmd_host_chk_sva.sv ====
// bus and mode checks on the host command sequencer ports
`timescale 1ns/1ns
module nor_cmd_host_chk (
	input wire logic                           sys_clk,
	input wire logic                           resetn,
	input wire logic                           cmd_valid,
	input wire logic                           cmd_ready,
	input wire nor_cmd_pkg::op_t               cmd_op,
	input wire logic                           cmd_refused,
	input wire logic                           bypass_r,
	input wire logic                           erasing_r,
	input wire logic                           suspended_r,
	input wire logic                           window_open,
	input wire logic                           chip_en_n,
	input wire logic                           write_en_n,
	input wire logic                           out_en_n,
	input wire logic [nor_cmd_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [nor_cmd_pkg::DATA_W-1:0] flash_dq_out,
	input wire logic                           flash_dq_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic take;
	// request seen in idle
	assign take = cmd_valid && cmd_ready;
	property p_rd_or_wr; !(!write_en_n && !out_en_n); endproperty
	a_rd_or_wr: assert property (p_rd_or_wr) else $error("both strobes low");
	property p_we_ce; !write_en_n |-> !chip_en_n && flash_dq_oe; endproperty
	a_we_ce: assert property (p_we_ce) else $error("bad write strobe");
	property p_hold; !write_en_n && $past(!write_en_n) |-> $stable(flash_addr) && $stable(flash_dq_out); endproperty
	a_hold: assert property (p_hold) else $error("bus moved in strobe");
	property p_width; $fell(write_en_n) |=> !write_en_n [*2] ##1 write_en_n; endproperty
	a_width: assert property (p_width) else $error("strobe width");
	property p_rd_float; !out_en_n |-> !flash_dq_oe; endproperty
	a_rd_float: assert property (p_rd_float) else $error("drive in read");
	property p_susp; take && cmd_op == nor_cmd_pkg::OP_SUSPEND && !erasing_r |-> cmd_refused; endproperty
	a_susp: assert property (p_susp) else $error("bad suspend");
	property p_res; take && cmd_op == nor_cmd_pkg::OP_RESUME && !suspended_r |-> cmd_refused; endproperty
	a_res: assert property (p_res) else $error("bad resume");
	property p_bprog; take && cmd_op == nor_cmd_pkg::OP_BYPASS_PROG && !bypass_r |-> cmd_refused; endproperty
	a_bprog: assert property (p_bprog) else $error("bad bypass program");
	property p_bonly; take && bypass_r && cmd_op == nor_cmd_pkg::OP_PROGRAM |-> cmd_refused; endproperty
	a_bonly: assert property (p_bonly) else $error("program in bypass");
	property p_win; window_open |-> erasing_r && !suspended_r; endproperty
	a_win: assert property (p_win) else $error("bad erase window");
	property p_quiet; cmd_refused |=> chip_en_n ##1 chip_en_n; endproperty
	a_quiet: assert property (p_quiet) else $error("refused on bus");
	c_susp: cover property (take && cmd_op == nor_cmd_pkg::OP_SUSPEND && !cmd_refused);
	c_byp: cover property ($rose(bypass_r));
	c_ref: cover property (cmd_refused);
endmodule // nor_cmd_host_chk

bind nor_cmd_host nor_cmd_host_chk i_nor_cmd_host_chk (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_refused(cmd_refused), .bypass_r(bypass_r), .erasing_r(erasing_r),
	.suspended_r(suspended_r), .window_open(window_open), .chip_en_n(chip_en_n), .write_en_n(write_en_n),
	.out_en_n(out_en_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));

// ==== nor_cmd_pkg.sv ====
// constants for the parallel nor flash command sequencer
package nor_cmd_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	// unlock and command addresses, word mode then byte mode
	localparam logic [10:0] UNLOCK1_WORD = 11'h555;
	localparam logic [10:0] UNLOCK2_WORD = 11'h2AA;
	localparam logic [10:0] QUERY_WORD   = 11'h055;
	localparam logic [10:0] QUERY_BYTE   = 11'h0AA;
	localparam logic [11:0] UNLOCK1_BYTE_FULL = 12'hAAA;
	// command codes (low byte only)
	localparam logic [7:0] CODE_UNLOCK1  = 8'hAA;
	localparam logic [7:0] CODE_UNLOCK2  = 8'h55;
	localparam logic [7:0] CODE_AUTOSEL  = 8'h90;
	localparam logic [7:0] CODE_RESET    = 8'hF0;
	localparam logic [7:0] CODE_REGION   = 8'h88;
	localparam logic [7:0] CODE_PROGRAM  = 8'hA0;
	localparam logic [7:0] CODE_BYPASS   = 8'h20;
	localparam logic [7:0] CODE_ERASE_SU = 8'h80;
	localparam logic [7:0] CODE_CHIP_ER  = 8'h10;
	localparam logic [7:0] CODE_SECT_ER  = 8'h30;
	localparam logic [7:0] CODE_SUSPEND  = 8'hB0;
	localparam logic [7:0] CODE_RESUME   = 8'h30;
	localparam logic [7:0] CODE_QUERY    = 8'h98;
	localparam logic [7:0] CODE_ZERO     = 8'h00;
	// commands presented to the sequencer
	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_AUTOSEL, OP_REGION_IN, OP_REGION_OUT, OP_PROGRAM,
		OP_BYPASS_IN, OP_BYPASS_PROG, OP_BYPASS_OUT, OP_CHIP_ERASE, OP_SECT_ERASE,
		OP_SECT_ADD, OP_SUSPEND, OP_RESUME, OP_QUERY
	} op_t;
	// bus timing in sys_clk cycles at 20 MHz
	localparam int CLK_MHZ       = 20;
	localparam int T_STROBE_NS   = 100;
	localparam int STROBE_CYC    = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WINDOW_US   = 50;
	localparam int WINDOW_CYC    = T_WINDOW_US * CLK_MHZ;
	localparam int CNT_W         = 11;
	localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
	localparam logic [CNT_W-1:0] WINDOW_CNT = CNT_W'(WINDOW_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO   = '0;
endpackage

// ==== nor_flash_model.sv ====
// behavioural flash device: array read, autoselect codes, reset
`timescale 1ns/1ns
module nor_flash_model #(
	parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h3C, // arbitrary value
	parameter logic       LOCKED = 1'b1
) (
	input wire logic        chip_en_n,
	input wire logic        write_en_n,
	input wire logic        out_en_n,
	input wire logic [19:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic        flash_dq_oe,
	output logic     [15:0] flash_dq_in
);
	logic [19:0] lat_a;
	logic [7:0]  h1 = 8'h00, h2 = 8'h00;
	logic        asel = 1'b0, wact = 1'b0;
	logic [15:0] rv, idv, last = 16'h0000;
	always @(negedge write_en_n or negedge chip_en_n) if (!write_en_n && !chip_en_n) begin
		lat_a = flash_addr;
		wact = 1'b1;
	end
	// data on first rise; low byte decodes
	always @(posedge write_en_n or posedge chip_en_n) if (wact) begin
		wact = 1'b0;
		if (flash_dq_out[7:0] == 8'hF0 || flash_dq_out[7:0] == 8'h00) asel = 1'b0;
		if (h2 == 8'hAA && h1 == 8'h55 && flash_dq_out[7:0] == 8'h90) asel = 1'b1;
		h2 = h1;
		h1 = flash_dq_out[7:0];
	end
	// identification; upper byte is junk on purpose
	always_comb begin
		case (flash_addr[7:0])
			8'h00: idv = {flash_addr[15:8], MFR_ID};
			8'h01: idv = {flash_addr[15:8], DEV_ID};
			8'h02: idv = {flash_addr[15:8], 7'h00, flash_addr[12]};
			8'h03: idv = {flash_addr[15:8], LOCKED ? 8'h81 : 8'h01};
			default: idv = 16'hFFFF;
		endcase
	end
	// array holds a fixed pattern of its address
	assign rv = asel ? idv : (flash_addr[15:0] ^ 16'hA5C3);
	// released bus shows the inverse so stale data never matches
	always @(posedge out_en_n) last <= rv;
	assign flash_dq_in = (!chip_en_n && !out_en_n) ? rv : ~last;
endmodule // nor_flash_model
